// [hdl/qpd_pkg.sv]
// Purpose: Shared constants and types for the quad potentiometer serial command decoder.
// Assumes: System clock of 250 MHz; serial frames of 8-bit bytes, most significant bit first.
// Notes: Frame offsets, field positions, wiper, setting and answer reset values and the write cycle count live here.
package qpd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Frame layout.
  localparam int HDR_TYPE_LSB = 12;
  localparam int HDR_MID_LSB = 10;
  localparam int HDR_ADDR_LSB = 8;
  localparam int HDR_OPC_LSB = 4;
  localparam int HDR_SEL_LSB = 2;
  localparam int HDR_POT_LSB = 0;
  localparam logic [4:0] HDR_LAST = 5'h0F;
  localparam logic [4:0] HDR_BITS = 5'h10;
  localparam logic [4:0] DATA_LAST = 5'h17;
  localparam logic [4:0] DATA_END = 5'h18;
  localparam logic [4:0] CNT_MAX = 5'h1F;

  // The value is arbitrary and does not name any real part.
  localparam logic [3:0] DEVICE_TYPE_ID = 4'hA;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction opcodes and fixed select patterns.
  localparam logic [3:0] OP_RD_WIPER = 4'h9;
  localparam logic [3:0] OP_WR_WIPER = 4'hA;
  localparam logic [3:0] OP_RD_SET = 4'hB;
  localparam logic [3:0] OP_WR_SET = 4'hC;
  localparam logic [3:0] OP_XFR_S2W = 4'hD;
  localparam logic [3:0] OP_XFR_W2S = 4'hE;
  localparam logic [3:0] OP_GXFR_S2W = 4'h1;
  localparam logic [3:0] OP_GXFR_W2S = 4'h8;
  localparam logic [3:0] OP_STEP = 4'h2;
  localparam logic [3:0] OP_STATUS = 4'h5;
  localparam logic [1:0] SEL_ZERO = 2'h0;
  localparam logic [1:0] POT_ZERO = 2'h0;
  localparam logic [1:0] STATUS_POT = 2'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and wiper limits.
  // Wipers leave reset at the low end so that the recall of setting zero is visible.
  localparam logic [7:0] WIPER_INIT = 8'h00;
  localparam logic [7:0] SETTING_INIT = 8'h80;
  localparam logic [7:0] WIPER_MIN = 8'h00;
  localparam logic [7:0] WIPER_MAX = 8'hFF;
  localparam logic [7:0] RESP_INIT = 8'h00;
  localparam logic [255:0] TAP_INIT = 256'h1 << WIPER_INIT;

  ////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int CLK_MHZ = 250;
  localparam int NV_WRITE_MS = 5;
  localparam int NV_WRITE_CYCLES = NV_WRITE_MS * 1000 * CLK_MHZ;
  localparam int NV_TMR_W = 21;

  ////////////////////////////////////////////////////////////////////////////
  // Wait state for the data byte of a write frame.
  typedef enum logic [2:0] {
    PEND_IDLE = 3'b001,
    PEND_WIPER = 3'b010,
    PEND_SET = 3'b100
  } qpd_pend_t;

endpackage : qpd_pkg

// [hdl/qpd_spi_decoder.sv]
// Purpose: Serial command decoder and register file of a quad digital potentiometer.
// Assumes: The serial clock idles low between frames; chip select is active low.
// Notes: Bit capture and the serial output run on the serial clock, shifting and decoding on the system clock.
`timescale 1ns/100ps

// How it works
// - Instruction byte high nibble is the opcode.
// - Bits three and two pick setting register.
// - Two low bits pick the potentiometer.
// - Four 8-bit wipers, one-hot tap decode each.
// - Wipers recall setting zero after power-up.
// - Sixteen 8-bit stored settings, freely readable, writable.
// - Setting change is a 5 ms write.
// - Save starts only at chip select release.
// - Busy flag high during the write cycle.
// - Opcode 1001 returns wiper position.
// - Opcode 1010 loads wiper from data byte.
// - Opcode 1011 returns chosen stored setting.
// - Opcode 1100 writes chosen stored setting.
// - Opcode 1110 saves wiper into chosen setting.
// - Opcode 1000 saves all wipers into settings.
// - Opcode 0010 enters step mode until frame ends.
// - Opcode 0101 pattern 0001 returns busy flag.
// - Step mode: high input up, low down.
// - Read, write, status frames carry data byte.
// - Transfer frames have no data byte.
// - Wrong device type field ignores the frame.
// - Two low address bits must match board address pins.
module qpd_spi_decoder #(
  parameter int unsigned NV_CYCLES = qpd_pkg::NV_WRITE_CYCLES
) (
  // System clock domain.
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  // Serial link pins.
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  // Board address straps.
  input wire logic [1:0] board_addr_i,
  // Potentiometer state.
  output logic [31:0] wiper_pos_o,
  output logic [1023:0] tap_sel_o,
  output logic write_busy_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock domain.
  logic [4:0] lk_cnt;
  logic lk_tgl;
  logic lk_bit;
  logic [7:0] so_sr;
  logic so_en;
  logic [7:0] resp_data;
  logic resp_valid;

  // The frame's own select ends the count, since the serial clock stops outside frames.
  always_ff @(posedge sck_i or posedge cs_n_i or posedge reset_i) begin
    if (reset_i || cs_n_i) begin
      lk_cnt <= 5'h00;
    end else if (lk_cnt != qpd_pkg::CNT_MAX) begin
      lk_cnt <= lk_cnt + 5'h01;
    end
  end

  // Each rising edge inside a frame hands one bit over by a toggle.
  always_ff @(posedge sck_i or posedge reset_i) begin
    if (reset_i) begin
      lk_tgl <= 1'b0;
      lk_bit <= 1'b0;
    end else if (!cs_n_i) begin
      lk_tgl <= ~lk_tgl;
      lk_bit <= si_i;
    end
  end

  // The answer is sampled half a serial period after the header's last bit.
  // The decoder settles it within a few system cycles, which limits the serial rate.
  always_ff @(negedge sck_i or posedge cs_n_i or posedge reset_i) begin
    if (reset_i || cs_n_i) begin
      so_sr <= 8'h00;
      so_en <= 1'b0;
    end else if (lk_cnt == qpd_pkg::HDR_BITS) begin
      so_sr <= resp_valid ? resp_data : 8'h00;
      so_en <= resp_valid;
    end else begin
      so_sr <= {so_sr[6:0], 1'b0};
    end
  end

  assign so_o = so_sr[7];
  assign so_oe_o = so_en;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers into the system domain.
  logic cs_s1;
  logic cs_s2;
  logic cs_s3;
  logic tgl_s1;
  logic tgl_s2;
  logic tgl_s3;
  logic [1:0] addr_s1;
  logic [1:0] addr_s2;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
      addr_s1 <= 2'h0;
      addr_s2 <= 2'h0;
    end else if (clk_en_i) begin
      cs_s1 <= cs_n_i;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      tgl_s1 <= lk_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
      addr_s1 <= board_addr_i;
      addr_s2 <= addr_s1;
    end
  end

  logic bit_ev;
  logic cs_rise;

  assign bit_ev = tgl_s2 ^ tgl_s3;
  assign cs_rise = cs_s2 & ~cs_s3;

  ////////////////////////////////////////////////////////////////////////////
  // Frame assembly.
  logic [4:0] cnt;
  logic [15:0] hdr;
  logic [7:0] data_sr;
  logic hdr_done;
  logic data_done;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt <= 5'h00;
      hdr <= 16'h0000;
      data_sr <= 8'h00;
      hdr_done <= 1'b0;
      data_done <= 1'b0;
    end else if (clk_en_i) begin
      if (cs_rise) begin
        cnt <= 5'h00;
        hdr_done <= 1'b0;
        data_done <= 1'b0;
      end else begin
        hdr_done <= bit_ev && (cnt == qpd_pkg::HDR_LAST);
        data_done <= bit_ev && (cnt == qpd_pkg::DATA_LAST);
        if (bit_ev) begin
          if (cnt < qpd_pkg::HDR_BITS) begin
            hdr <= {hdr[14:0], lk_bit};
          end else if (cnt < qpd_pkg::DATA_END) begin
            data_sr <= {data_sr[6:0], lk_bit};
          end
          if (cnt != qpd_pkg::CNT_MAX) begin
            cnt <= cnt + 5'h01;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decode.
  logic [3:0] op;
  logic [1:0] sel;
  logic [1:0] pot;
  logic match;
  logic exec;
  logic do_rd_wiper;
  logic do_wr_wiper;
  logic do_rd_set;
  logic do_wr_set;
  logic do_xfr_s2w;
  logic do_xfr_w2s;
  logic do_gxfr_s2w;
  logic do_gxfr_w2s;
  logic do_step;
  logic do_status;

  assign op = hdr[qpd_pkg::HDR_OPC_LSB +: 4];
  assign sel = hdr[qpd_pkg::HDR_SEL_LSB +: 2];
  assign pot = hdr[qpd_pkg::HDR_POT_LSB +: 2];
  // The two middle address bits are not checked; the master is trusted to send zeros.
  assign match = (hdr[qpd_pkg::HDR_TYPE_LSB +: 4] == qpd_pkg::DEVICE_TYPE_ID)
    && (hdr[qpd_pkg::HDR_ADDR_LSB +: 2] == addr_s2);
  assign exec = hdr_done & match;

  // Patterns outside this set leave every register and the write cycle alone.
  assign do_rd_wiper = exec && (op == qpd_pkg::OP_RD_WIPER) && (sel == qpd_pkg::SEL_ZERO);
  assign do_wr_wiper = exec && (op == qpd_pkg::OP_WR_WIPER) && (sel == qpd_pkg::SEL_ZERO);
  assign do_rd_set = exec && (op == qpd_pkg::OP_RD_SET);
  assign do_wr_set = exec && (op == qpd_pkg::OP_WR_SET);
  assign do_xfr_s2w = exec && (op == qpd_pkg::OP_XFR_S2W);
  assign do_xfr_w2s = exec && (op == qpd_pkg::OP_XFR_W2S);
  assign do_gxfr_s2w = exec && (op == qpd_pkg::OP_GXFR_S2W) && (pot == qpd_pkg::POT_ZERO);
  assign do_gxfr_w2s = exec && (op == qpd_pkg::OP_GXFR_W2S) && (pot == qpd_pkg::POT_ZERO);
  assign do_step = exec && (op == qpd_pkg::OP_STEP) && (sel == qpd_pkg::SEL_ZERO);
  assign do_status = exec && (op == qpd_pkg::OP_STATUS) && (sel == qpd_pkg::SEL_ZERO)
    && (pot == qpd_pkg::STATUS_POT);

  ////////////////////////////////////////////////////////////////////////////
  // Data byte wait and step mode.
  qpd_pkg::qpd_pend_t pend;
  logic step_mode;
  logic step_ev;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pend <= qpd_pkg::PEND_IDLE;
    end else if (clk_en_i) begin
      if (cs_rise || data_done) begin
        pend <= qpd_pkg::PEND_IDLE;
      end else if (do_wr_wiper) begin
        pend <= qpd_pkg::PEND_WIPER;
      end else if (do_wr_set) begin
        pend <= qpd_pkg::PEND_SET;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      step_mode <= 1'b0;
    end else if (clk_en_i) begin
      if (cs_rise) begin
        step_mode <= 1'b0;
      end else if (do_step) begin
        step_mode <= 1'b1;
      end
    end
  end

  assign step_ev = step_mode & bit_ev;

  ////////////////////////////////////////////////////////////////////////////
  // Read answers.
  logic busy;
  logic [31:0] wiper_flat;
  logic [127:0] set_flat;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      resp_data <= qpd_pkg::RESP_INIT;
      resp_valid <= 1'b0;
    end else if (clk_en_i) begin
      if (cs_rise) begin
        resp_valid <= 1'b0;
      end else if (do_rd_wiper) begin
        resp_data <= wiper_flat[{pot, 3'b000} +: 8];
        resp_valid <= 1'b1;
      end else if (do_rd_set) begin
        resp_data <= set_flat[{pot, sel, 3'b000} +: 8];
        resp_valid <= 1'b1;
      end else if (do_status) begin
        resp_data <= {7'h00, busy};
        resp_valid <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending non-volatile save and its write cycle.
  logic nv_pend;
  logic [3:0] nv_mask;
  logic [1:0] nv_sel;
  logic nv_use_data;
  logic [7:0] nv_data;
  logic commit;
  logic [qpd_pkg::NV_TMR_W-1:0] nv_tmr;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      nv_pend <= 1'b0;
      nv_mask <= 4'h0;
      nv_sel <= 2'h0;
      nv_use_data <= 1'b0;
      nv_data <= 8'h00;
    end else if (clk_en_i) begin
      if (cs_rise) begin
        nv_pend <= 1'b0;
      end else if (do_xfr_w2s || do_gxfr_w2s) begin
        nv_pend <= 1'b1;
        nv_mask <= do_gxfr_w2s ? 4'hF : (4'h1 << pot);
        nv_sel <= sel;
        nv_use_data <= 1'b0;
      end else if (data_done && (pend == qpd_pkg::PEND_SET)) begin
        nv_pend <= 1'b1;
        nv_mask <= 4'h1 << pot;
        nv_sel <= sel;
        nv_use_data <= 1'b1;
        nv_data <= data_sr;
      end
    end
  end

  // A save requested while the previous one still runs is dropped.
  assign commit = cs_rise & nv_pend & ~busy;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      nv_tmr <= '0;
      busy <= 1'b0;
    end else if (clk_en_i) begin
      if (commit) begin
        nv_tmr <= qpd_pkg::NV_TMR_W'(NV_CYCLES);
        busy <= 1'b1;
      end else if (nv_tmr != '0) begin
        nv_tmr <= nv_tmr - qpd_pkg::NV_TMR_W'(1);
        busy <= (nv_tmr != qpd_pkg::NV_TMR_W'(1));
      end
    end
  end

  assign write_busy_o = busy;

  ////////////////////////////////////////////////////////////////////////////
  // Power-up recall strobe.
  logic recall;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      recall <= 1'b1;
    end else if (clk_en_i) begin
      recall <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per potentiometer wiper, stored settings and tap decode.
  for (genvar p = 0; p < 4; p++) begin : g_pot
    logic [7:0] wiper;
    logic [7:0] store [4];
    logic [255:0] tap;

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
        wiper <= qpd_pkg::WIPER_INIT;
      end else if (clk_en_i) begin
        if (recall) begin
          wiper <= store[0];
        end else if ((do_xfr_s2w && (pot == 2'(p))) || do_gxfr_s2w) begin
          wiper <= store[sel];
        end else if (data_done && (pend == qpd_pkg::PEND_WIPER) && (pot == 2'(p))) begin
          wiper <= data_sr;
        end else if (step_ev && (pot == 2'(p))) begin
          if (lk_bit && (wiper != qpd_pkg::WIPER_MAX)) begin
            wiper <= wiper + 8'h01;
          end else if (!lk_bit && (wiper != qpd_pkg::WIPER_MIN)) begin
            wiper <= wiper - 8'h01;
          end
        end
      end
    end

    // Stored settings are flip-flops here; a reset stands in for the non-volatile contents.
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
        for (int r = 0; r < 4; r++) begin
          store[r] <= qpd_pkg::SETTING_INIT;
        end
      end else if (clk_en_i) begin
        if (commit && nv_mask[p]) begin
          store[nv_sel] <= nv_use_data ? nv_data : wiper;
        end
      end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
        tap <= qpd_pkg::TAP_INIT;
      end else if (clk_en_i) begin
        tap <= 256'h1 << wiper;
      end
    end

    assign wiper_flat[p*8 +: 8] = wiper;
    assign set_flat[p*32 +: 32] = {store[3], store[2], store[1], store[0]};
    assign tap_sel_o[p*256 +: 256] = tap;
  end

  assign wiper_pos_o = wiper_flat;

endmodule : qpd_spi_decoder

// [dv/qpd_spi_decoder_asserts.sv]
// Purpose: Concurrent checks on the ports of the potentiometer command decoder.
// Assumes: Bound to every instance of the decoder; one system clock domain.
// Notes: Busy length is counted in helper logic because the write time is long.
`timescale 1ns/100ps
module qpd_spi_decoder_asserts #(
  parameter int unsigned NV_CYCLES = 1
) (
  // System side.
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  // Link side.
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic so_o,
  input wire logic so_oe_o,
  input wire logic [1:0] board_addr_i,
  // Potentiometer state.
  input wire logic [31:0] wiper_pos_o,
  input wire logic [1023:0] tap_sel_o,
  input wire logic write_busy_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  int unsigned busy_cnt;
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_cnt <= 0;
    end else if (write_busy_o) begin
      busy_cnt <= busy_cnt + 1;
    end else begin
      busy_cnt <= 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_cs_quiet;
    cs_n_i [*8];
  endsequence
  sequence s_save_start;
    $rose(write_busy_o);
  endsequence
  property p_oe_cs; cs_n_i |-> !so_oe_o; endproperty
  property p_so_quiet; !so_oe_o |-> !so_o; endproperty
  property p_tap;
    tap_sel_o[255:0] == (256'h1 << $past(wiper_pos_o[7:0])) &&
      tap_sel_o[1023:768] == (256'h1 << $past(wiper_pos_o[31:24]));
  endproperty
  property p_busy_len; write_busy_o |-> busy_cnt < NV_CYCLES; endproperty
  property p_busy_full; $fell(write_busy_o) |-> busy_cnt == NV_CYCLES; endproperty
  property p_save_cs; s_save_start |-> cs_n_i; endproperty
  property p_wiper_idle; s_cs_quiet |-> $stable(wiper_pos_o); endproperty
  property p_recall; $fell(reset_i) |-> ##1 wiper_pos_o == {4{qpd_pkg::SETTING_INIT}}; endproperty
  a_oe_cs: assert property (p_oe_cs) else $error("output enabled while deselected");
  a_so_quiet: assert property (p_so_quiet) else $error("serial output high while idle");
  a_tap: assert property (p_tap) else $error("tap select does not follow wiper");
  a_busy_len: assert property (p_busy_len) else $error("write cycle too long");
  a_busy_full: assert property (p_busy_full) else $error("write cycle length wrong");
  a_save_cs: assert property (p_save_cs) else $error("save started inside a frame");
  a_wiper_idle: assert property (p_wiper_idle) else $error("wiper moved between frames");
  a_recall: assert property (p_recall) else $error("wiper not recalled after reset");
endmodule : qpd_spi_decoder_asserts

bind qpd_spi_decoder qpd_spi_decoder_asserts #(.NV_CYCLES(NV_CYCLES)) qpd_spi_decoder_asserts_inst (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i), .sck_i(sck_i), .cs_n_i(cs_n_i),
  .si_i(si_i), .so_o(so_o), .so_oe_o(so_oe_o), .board_addr_i(board_addr_i), .wiper_pos_o(wiper_pos_o),
  .tap_sel_o(tap_sel_o), .write_busy_o(write_busy_o));

// [dv/qpd_spi_master.sv]
// Purpose: Behavioural serial bus master facing the decoder's link pins.
// Assumes: Mode 0, most significant bit first, 64 ns serial clock.
// Notes: The serial clock stands still low between frames.
`timescale 1ns/100ps
module qpd_spi_master (
  // Link pins.
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o,
  input wire logic so_i
);
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end
  // Sends the top n bits of b; the odd offsets keep link edges clear of the system clock edges.
  task automatic frame(input logic [23:0] b, input int n, output logic [7:0] rd);
    rd = 8'h00;
    #13 cs_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      si_o = b[23 - i];
      #32 sck_o = 1'b1;
      rd = {rd[6:0], so_i};
      #32 sck_o = 1'b0;
    end
    #16 si_o = ~si_o;
    cs_n_o = 1'b1;
    #255;
  endtask : frame
endmodule : qpd_spi_master

// [dv/tb.sv]
// Purpose: Self-checking bench for the potentiometer command decoder.
// Assumes: A short write cycle parameter so the run stays brief.
// Notes: Expected register contents are kept in local arrays.
`timescale 1ns/100ps
module tb;
  localparam int NV = 2000;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic clk_en_i = 1'b1;
  logic [1:0] board_addr_i = 2'h2;
  logic sck_i, cs_n_i, si_i, so_o, so_oe_o, write_busy_o;
  logic [31:0] wiper_pos_o;
  logic [1023:0] tap_sel_o;
  logic [7:0] rd;
  logic [7:0] set_m [16];
  logic [7:0] wip_m [4];
  int miscompares = 0;
  int compares = 0;
  always #2 sys_clk_i = ~sys_clk_i;
  qpd_spi_decoder #(.NV_CYCLES(NV)) qpd_spi_decoder_inst (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .clk_en_i(clk_en_i), .sck_i(sck_i), .cs_n_i(cs_n_i), .si_i(si_i), .so_o(so_o), .so_oe_o(so_oe_o),
    .board_addr_i(board_addr_i), .wiper_pos_o(wiper_pos_o), .tap_sel_o(tap_sel_o),
    .write_busy_o(write_busy_o));
  qpd_spi_master qpd_spi_master_inst (.sck_o(sck_i), .cs_n_o(cs_n_i), .si_o(si_i), .so_i(so_o));
  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (miscompares == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chkw();
    for (int p = 0; p < 4; p++) begin
      chk("wiper", wip_m[p], wiper_pos_o[8 * p +: 8]);
      chk("tap bit", 8'h01, {7'h00, tap_sel_o[256 * p + wip_m[p]]});
      chk("tap count", 8'h01, 8'($countones(tap_sel_o[256 * p +: 256])));
    end
  endtask : chkw
  task automatic raw(input logic [3:0] ty, input logic [1:0] ad, input logic [3:0] op, input logic [1:0] sel,
                     input logic [1:0] pot, input logic [7:0] d, input int n);
    qpd_spi_master_inst.frame({ty, 2'h0, ad, op, sel, pot, d}, n, rd);
  endtask : raw
  task automatic cmd(input logic [3:0] op, input logic [1:0] sel, input logic [1:0] pot, input logic [7:0] d,
                     input int n);
    raw(qpd_pkg::DEVICE_TYPE_ID, board_addr_i, op, sel, pot, d, n);
  endtask : cmd
  // A stuck busy flag would hang every later save, so the wait is bounded.
  task automatic wait_idle();
    int k;
    k = 0;
    while (write_busy_o !== 1'b0 && k < NV + 100) begin
      @(negedge sys_clk_i);
      k++;
    end
    if (k >= NV + 100) begin
      miscompares++;
      print_verdict();
    end
  endtask : wait_idle
  task automatic do_reset();
    foreach (set_m[i]) set_m[i] = qpd_pkg::SETTING_INIT;
    foreach (wip_m[i]) wip_m[i] = qpd_pkg::SETTING_INIT;
    reset_i = 1'b1;
    repeat (10) @(negedge sys_clk_i);
    reset_i = 1'b0;
    repeat (8) @(negedge sys_clk_i);
    chkw();
  endtask : do_reset
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    for (int p = 0; p < 4; p++) begin
      wip_m[p] = {6'h0D, p[1:0]};
      cmd(qpd_pkg::OP_WR_WIPER, qpd_pkg::SEL_ZERO, p[1:0], wip_m[p], 24);
    end
    for (int p = 0; p < 4; p++) begin
      cmd(qpd_pkg::OP_RD_WIPER, qpd_pkg::SEL_ZERO, p[1:0], 8'h00, 24);
      chk("wiper read", wip_m[p], rd);
    end
    chkw();
    for (int s = 0; s < 4; s++) begin
      set_m[4 + s] = {6'h31, s[1:0]};
      cmd(qpd_pkg::OP_WR_SET, s[1:0], 2'h1, set_m[4 + s], 24);
      cmd(qpd_pkg::OP_STATUS, qpd_pkg::SEL_ZERO, qpd_pkg::STATUS_POT, 8'h00, 24);
      chk("busy status", 8'h01, rd);
      wait_idle();
    end
    cmd(qpd_pkg::OP_STATUS, qpd_pkg::SEL_ZERO, qpd_pkg::STATUS_POT, 8'h00, 24);
    chk("idle status", 8'h00, rd);
    for (int s = 0; s < 4; s++) begin
      cmd(qpd_pkg::OP_RD_SET, s[1:0], 2'h1, 8'h00, 24);
      chk("setting", set_m[4 + s], rd);
    end
    wip_m[1] = set_m[6];
    cmd(qpd_pkg::OP_XFR_S2W, 2'h2, 2'h1, 8'h00, 16);
    chkw();
    set_m[11] = wip_m[2];
    cmd(qpd_pkg::OP_XFR_W2S, 2'h3, 2'h2, 8'h00, 16);
    wait_idle();
    cmd(qpd_pkg::OP_RD_SET, 2'h3, 2'h2, 8'h00, 24);
    chk("saved wiper", set_m[11], rd);
    for (int p = 0; p < 4; p++) set_m[4 * p + 1] = wip_m[p];
    cmd(qpd_pkg::OP_GXFR_W2S, 2'h1, qpd_pkg::POT_ZERO, 8'h00, 16);
    wait_idle();
    for (int p = 0; p < 4; p++) wip_m[p] = set_m[4 * p + 3];
    cmd(qpd_pkg::OP_GXFR_S2W, 2'h3, qpd_pkg::POT_ZERO, 8'h00, 16);
    chkw();
    for (int p = 0; p < 4; p++) begin
      cmd(qpd_pkg::OP_RD_SET, 2'h1, p[1:0], 8'h00, 24);
      chk("global save", set_m[4 * p + 1], rd);
    end
    cmd(qpd_pkg::OP_WR_WIPER, qpd_pkg::SEL_ZERO, 2'h0, 8'hFE, 24);
    cmd(qpd_pkg::OP_STEP, qpd_pkg::SEL_ZERO, 2'h0, 8'hE0, 21);
    wip_m[0] = 8'hFD;
    chkw();
    cmd(qpd_pkg::OP_WR_WIPER, qpd_pkg::SEL_ZERO, 2'h0, 8'h01, 24);
    cmd(qpd_pkg::OP_STEP, qpd_pkg::SEL_ZERO, 2'h0, 8'h18, 21);
    wip_m[0] = 8'h02;
    chkw();
    raw(4'h3, board_addr_i, qpd_pkg::OP_WR_WIPER, 2'h0, 2'h0, 8'h55, 24);
    chkw();
    raw(qpd_pkg::DEVICE_TYPE_ID, ~board_addr_i, qpd_pkg::OP_WR_WIPER, 2'h0, 2'h0, 8'h55, 24);
    chkw();
    cmd(4'hF, 2'h0, 2'h0, 8'h55, 24);
    chkw();
    cmd(qpd_pkg::OP_WR_SET, 2'h0, 2'h0, 8'h55, 20);
    chk("busy after short frame", 8'h00, {7'h00, write_busy_o});
    do_reset();
    cmd(qpd_pkg::OP_RD_SET, 2'h3, 2'h1, 8'h00, 24);
    chk("setting after reset", qpd_pkg::SETTING_INIT, rd);
    print_verdict();
  end
endmodule : tb
